// >>> core/psi_params.svh
`ifndef PSI_PARAMS_SVH
`define PSI_PARAMS_SVH
// register addresses
`define PSI_A_P2DATA 8'h02
`define PSI_A_P3DATA 8'h03
`define PSI_A_SIO    8'hf0
`define PSI_A_T0     8'hf4
`define PSI_A_P2MODE 8'hf6
`define PSI_A_P3MODE 8'hf7
`define PSI_A_IPR    8'hf9
`define PSI_A_IRQ    8'hfa
`define PSI_A_IMR    8'hfb
`define PSI_A_STAT   8'hfc
// port-three mode bits
`define PSI_M_OD     0
`define PSI_M_P2HS   1
`define PSI_M_P0HS   2
`define PSI_M_TMR    3
`define PSI_M_DM     4
`define PSI_M_SER    5
`define PSI_M_PAR    6
// interrupt mask global enable bit
`define PSI_IMR_GE   7
// reset values
`define PSI_RST_DIR  8'hff
`define PSI_RST_T0   8'h00
// serial framing
`define PSI_OVS_LAST 4'hf
`define PSI_OVS_MID  4'h7
`define PSI_TX_BITS  4'hb
`define PSI_RX_STOP  4'h9
// interrupt entry timing in clocks after the sample point
`define PSI_PUSH_END 6'h30
`define PSI_FTCH_END 6'h39
`define PSI_ISR_AT   6'h3a
`endif

// >>> core/psi_pkg.sv
package psi_pkg;
   // register bus request from the core
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } psi_bus_t;
   // interrupt entry sequence
   typedef enum logic [1:0] {
      INT_IDLE,
      INT_PUSH,
      INT_FETCH
   } psi_int_st_t;
endpackage : psi_pkg

// >>> core/psi_port.sv
// Chosen here: the register offsets and the address-and-strobe port.
`include "psi_params.svh"
// Function
// - each port-two line is input or output; all outputs may be open-drain
// - port-two handshake on line1/line6, roles set by direction of line7
// - port three has four fixed inputs and four fixed outputs
// - in serial mode line0 receives and line7 transmits
// - input lines 0,1,2,3 feed requests three, two, zero, one
// - line1 timer input, line6 timer output, line4 memory select, 2/5 handshake
// - serial bit rate comes from counter/timer zero
// - transmit frame is start, eight data bits, two stop bits
// - parity option replaces data bit eight by odd parity of seven
// - every sent character raises request four
// - with parity, received bit seven holds the parity error flag
// - every received character raises request three
// - nine sources merge into six maskable prioritised requests
// - mask register enables requests globally and individually
// - priority register programs which pending request wins
// - a grant disables interrupts, saves state and fetches a vector pair
// - requests readable while masked; writing one makes a request pending
// - requests sampled at the end of each instruction, held until granted
// - 48 clocks pushing, nine fetching, service starts at clock 58
// - priority register is write-only at f9
// - port-three mode register is write-only at f7
module psi_port (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire psi_pkg::psi_bus_t bus,
   output logic [7:0]             rd_data,
   input  wire logic [7:0]        p2_in,
   output logic [7:0]             p2_out,
   output logic [7:0]             p2_oe,
   input  wire logic [3:0]        p3_in,
   output logic [7:4]             p3_out,
   input  wire logic              instr_last,
   input  wire logic [1:0]        timer_evt,
   input  wire logic              timer_out_src,
   input  wire logic              data_memory_select,
   input  wire logic              ready_port0,
   output logic                   timer_input,
   output logic                   data_available_port0,
   output logic                   int_ack,
   output logic                   int_push,
   output logic                   int_fetch,
   output logic                   int_isr_start,
   output logic [7:0]             int_vector
);

   // odd parity over seven bits
   function automatic logic psi_odd(input logic [6:0] d);
      psi_odd = ~^d;
   endfunction : psi_odd

   // pick first pending request starting at the programmed index
   function automatic logic [2:0] psi_pick(input logic [5:0] p,
                                           input logic [2:0] s);
      logic [2:0] i;
      psi_pick = s;
      for (int k = 5; k >= 0; k--) begin
         i = 3'((32'(s) + k) % 6);
         if (p[i]) psi_pick = i;
      end
   endfunction : psi_pick

   logic [1:0]  rst_sh_q;
   logic        rs_n;
   logic [7:0]  p2_s1_q, p2_s2_q;
   logic [3:0]  p3_s1_q, p3_s2_q, p3_d_q;
   logic [7:0]  p2_dir_q, p2_dat_q, p2_lat_q, p3_dat_q;
   logic [7:0]  p3m_q, ipr_q, imr_q, t0_rld_q, t0_cnt_q;
   logic [5:0]  req_q, req_set;
   logic        tick;
   logic        wr_sio, wr_p2;
   logic [10:0] tx_sh_q;
   logic [3:0]  tx_cnt_q, tx_os_q;
   logic        tx_busy, tx_done;
   logic [7:0]  rx_sh_q, rx_dat_q;
   logic [3:0]  rx_cnt_q, rx_os_q;
   logic        rx_act_q, rx_done_q, rx_full_q;
   logic        hs_dav_q, hs_rdy_q;
   logic        grant;
   logic [5:0]  pend;
   logic [5:0]  int_cnt_q;
   psi_pkg::psi_int_st_t int_st_q;
   logic [3:0]  fell;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) rst_sh_q <= 2'h0;
      else        rst_sh_q <= {rst_sh_q[0], 1'b1};
   end
   assign rs_n = rst_sh_q[1];

   // pin synchronisers and edge history
   always_ff @(posedge core_clk or negedge rs_n) begin
      if (!rs_n) begin
         p2_s1_q <= 8'h00;
         p2_s2_q <= 8'h00;
         p3_s1_q <= 4'hf;
         p3_s2_q <= 4'hf;
         p3_d_q  <= 4'hf;
      end else begin
         p2_s1_q <= p2_in;
         p2_s2_q <= p2_s1_q;
         p3_s1_q <= p3_in;
         p3_s2_q <= p3_s1_q;
         p3_d_q  <= p3_s2_q;
      end
   end
   assign fell = p3_d_q & ~p3_s2_q;

   assign wr_sio = bus.wr && bus.addr == `PSI_A_SIO;
   assign wr_p2  = bus.wr && bus.addr == `PSI_A_P2DATA;

   // software control registers
   always_ff @(posedge core_clk or negedge rs_n) begin
      if (!rs_n) begin
         p2_dir_q <= `PSI_RST_DIR;
         p2_dat_q <= 8'h00;
         p3_dat_q <= 8'h00;
         p3m_q    <= 8'h00;
         ipr_q    <= 8'h00;
         t0_rld_q <= `PSI_RST_T0;
      end else if (bus.wr) begin
         case (bus.addr)
            `PSI_A_P2DATA: p2_dat_q <= bus.wdata;
            `PSI_A_P3DATA: p3_dat_q <= bus.wdata;
            `PSI_A_P2MODE: p2_dir_q <= bus.wdata;
            `PSI_A_P3MODE: p3m_q    <= bus.wdata;
            `PSI_A_IPR:    ipr_q    <= bus.wdata;
            `PSI_A_T0:     t0_rld_q <= bus.wdata;
            default: ;
         endcase
      end
   end

   // counter/timer zero gives the oversampling tick
   always_ff @(posedge core_clk or negedge rs_n) begin
      if (!rs_n)                 t0_cnt_q <= `PSI_RST_T0;
      else if (t0_cnt_q == 8'h00) t0_cnt_q <= t0_rld_q;
      else                       t0_cnt_q <= t0_cnt_q - 8'h01;
   end
   assign tick = t0_cnt_q == 8'h00;

   // transmitter: frame shifted out lsb first
   always_ff @(posedge core_clk or negedge rs_n) begin
      if (!rs_n) begin
         tx_sh_q  <= 11'h7ff;
         tx_cnt_q <= 4'h0;
         tx_os_q  <= 4'h0;
      end else if (wr_sio && !tx_busy && p3m_q[`PSI_M_SER]) begin
         tx_sh_q  <= {2'h3,
                      p3m_q[`PSI_M_PAR] ? psi_odd(bus.wdata[6:0])
                                        : bus.wdata[7],
                      bus.wdata[6:0], 1'b0};
         tx_cnt_q <= `PSI_TX_BITS;
         tx_os_q  <= 4'h0;
      end else if (tx_busy && tick) begin
         tx_os_q <= tx_os_q + 4'h1;
         if (tx_os_q == `PSI_OVS_LAST) begin
            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
            tx_cnt_q <= tx_cnt_q - 4'h1;
         end
      end
   end
   assign tx_busy = tx_cnt_q != 4'h0;
   assign tx_done = tick && tx_cnt_q == 4'h1 && tx_os_q == `PSI_OVS_LAST;

   // receiver: mid-bit sampling, lsb first
   always_ff @(posedge core_clk or negedge rs_n) begin
      if (!rs_n) begin
         rx_act_q  <= 1'b0;
         rx_os_q   <= 4'h0;
         rx_cnt_q  <= 4'h0;
         rx_sh_q   <= 8'h00;
         rx_done_q <= 1'b0;
      end else begin
         rx_done_q <= 1'b0;
         if (!rx_act_q) begin
            if (p3m_q[`PSI_M_SER] && !p3_s2_q[0]) begin
               rx_act_q <= 1'b1;
               rx_os_q  <= 4'h0;
               rx_cnt_q <= 4'h0;
            end
         end else if (tick) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == `PSI_OVS_MID) begin
               rx_cnt_q <= rx_cnt_q + 4'h1;
               if (rx_cnt_q == 4'h0 && p3_s2_q[0]) rx_act_q <= 1'b0;
               else if (rx_cnt_q == `PSI_RX_STOP) begin
                  rx_act_q  <= 1'b0;
                  rx_done_q <= 1'b1;
               end else if (rx_cnt_q != 4'h0)
                  rx_sh_q <= {p3_s2_q[0], rx_sh_q[7:1]};
            end
         end
      end
   end

   // received character buffer with optional parity check
   always_ff @(posedge core_clk or negedge rs_n) begin
      if (!rs_n) begin
         rx_dat_q  <= 8'h00;
         rx_full_q <= 1'b0;
      end else if (rx_done_q) begin
         rx_full_q <= 1'b1;
         rx_dat_q  <= p3m_q[`PSI_M_PAR] ?
            {rx_sh_q[7] != psi_odd(rx_sh_q[6:0]), rx_sh_q[6:0]} : rx_sh_q;
      end else if (bus.rd && bus.addr == `PSI_A_SIO) rx_full_q <= 1'b0;
   end

   // request sources merged into six requests
   always_comb begin
      req_set    = 6'h00;
      req_set[0] = fell[2];
      req_set[1] = fell[3];
      req_set[2] = fell[1];
      req_set[3] = p3m_q[`PSI_M_SER] ? rx_done_q : fell[0];
      req_set[4] = p3m_q[`PSI_M_SER] ? tx_done : tick;
      req_set[5] = |timer_evt;
      if (bus.wr && bus.addr == `PSI_A_IRQ)
         req_set = req_set | bus.wdata[5:0];
   end

   assign pend  = req_q & imr_q[5:0];
   assign grant = instr_last && imr_q[`PSI_IMR_GE] && |pend &&
                  int_st_q == psi_pkg::INT_IDLE;

   // pending requests: a new set wins over the grant clear
   always_ff @(posedge core_clk or negedge rs_n) begin
      if (!rs_n) req_q <= 6'h00;
      else if (grant)
         req_q <= (req_q & ~(6'h01 << psi_pick(pend, ipr_q[2:0])))
                  | req_set;
      else       req_q <= req_q | req_set;
   end

   // mask register; a grant clears the global enable
   always_ff @(posedge core_clk or negedge rs_n) begin
      if (!rs_n) imr_q <= 8'h00;
      else if (grant) imr_q[`PSI_IMR_GE] <= 1'b0;
      else if (bus.wr && bus.addr == `PSI_A_IMR) imr_q <= bus.wdata;
   end

   // interrupt entry sequence: push, vector fetch, service start
   always_ff @(posedge core_clk or negedge rs_n) begin
      if (!rs_n) begin
         int_st_q      <= psi_pkg::INT_IDLE;
         int_cnt_q     <= 6'h00;
         int_vector    <= 8'h00;
         int_isr_start <= 1'b0;
      end else begin
         int_isr_start <= 1'b0;
         case (int_st_q)
            psi_pkg::INT_IDLE: begin
               if (grant) begin
                  int_st_q   <= psi_pkg::INT_PUSH;
                  int_cnt_q  <= 6'h01;
                  int_vector <= {4'h0, psi_pick(pend, ipr_q[2:0]), 1'b0};
               end
            end
            psi_pkg::INT_PUSH: begin
               int_cnt_q <= int_cnt_q + 6'h01;
               if (int_cnt_q == `PSI_PUSH_END)
                  int_st_q <= psi_pkg::INT_FETCH;
            end
            psi_pkg::INT_FETCH: begin
               int_cnt_q <= int_cnt_q + 6'h01;
               if (int_cnt_q == `PSI_FTCH_END) begin
                  int_st_q      <= psi_pkg::INT_IDLE;
                  int_isr_start <= 1'b1;
               end
            end
            default: int_st_q <= psi_pkg::INT_IDLE;
         endcase
      end
   end
   assign int_ack   = int_st_q != psi_pkg::INT_IDLE;
   assign int_push  = int_st_q == psi_pkg::INT_PUSH;
   assign int_fetch = int_st_q == psi_pkg::INT_FETCH;

   // port-two handshake on port-three lines one and six
   always_ff @(posedge core_clk or negedge rs_n) begin
      if (!rs_n) begin
         hs_dav_q <= 1'b1;
         hs_rdy_q <= 1'b1;
         p2_lat_q <= 8'h00;
      end else if (p2_dir_q[7]) begin
         hs_dav_q <= 1'b1;
         if (hs_rdy_q && fell[1]) begin
            p2_lat_q <= p2_s2_q;
            hs_rdy_q <= 1'b0;
         end else if (bus.rd && bus.addr == `PSI_A_P2DATA)
            hs_rdy_q <= 1'b1;
      end else begin
         hs_rdy_q <= 1'b1;
         if (wr_p2) hs_dav_q <= 1'b0;
         else if (p3_s2_q[1]) hs_dav_q <= 1'b1;
      end
   end

   // pin drivers, all from flops
   always_ff @(posedge core_clk or negedge rs_n) begin
      if (!rs_n) begin
         p2_out <= 8'h00;
         p2_oe  <= 8'h00;
         p3_out <= 4'hf;
         timer_input          <= 1'b0;
         data_available_port0 <= 1'b1;
      end else begin
         p2_out <= p2_dat_q;
         p2_oe  <= ~p2_dir_q &
                   ~(p2_dat_q & {8{p3m_q[`PSI_M_OD]}});
         p3_out[4] <= p3m_q[`PSI_M_DM] ? data_memory_select
                                       : p3_dat_q[4];
         p3_out[5] <= p3m_q[`PSI_M_P0HS] ? ready_port0 : p3_dat_q[5];
         p3_out[6] <= p3m_q[`PSI_M_TMR] ? timer_out_src :
                      p3m_q[`PSI_M_P2HS] ? (p2_dir_q[7] ? hs_rdy_q
                                                        : hs_dav_q)
                                         : p3_dat_q[6];
         p3_out[7] <= p3m_q[`PSI_M_SER] ?
                      (tx_busy ? tx_sh_q[0] : 1'b1) : p3_dat_q[7];
         timer_input          <= p3m_q[`PSI_M_TMR] & p3_s2_q[1];
         data_available_port0 <= p3m_q[`PSI_M_P0HS] ? p3_s2_q[2] : 1'b1;
      end
   end

   // read port, data one cycle after the strobe
   always_ff @(posedge core_clk or negedge rs_n) begin
      if (!rs_n) rd_data <= 8'h00;
      else if (bus.rd) begin
         case (bus.addr)
            `PSI_A_P2DATA: rd_data <= p2_dir_q[7] && p3m_q[`PSI_M_P2HS]
                                   ? p2_lat_q
                                   : (p2_dir_q & p2_s2_q)
                                     | (~p2_dir_q & p2_dat_q);
            `PSI_A_P3DATA: rd_data <= {p3_out, p3_s2_q};
            `PSI_A_SIO:    rd_data <= rx_dat_q;
            `PSI_A_T0:     rd_data <= t0_cnt_q;
            `PSI_A_P2MODE: rd_data <= p2_dir_q;
            `PSI_A_IRQ:    rd_data <= {2'h0, req_q};
            `PSI_A_IMR:    rd_data <= imr_q;
            `PSI_A_STAT:   rd_data <= {5'h00, int_ack, rx_full_q, tx_busy};
            default:       rd_data <= 8'h00;
         endcase
      end else rd_data <= 8'h00;
   end

   a_grant_di: assert property (
      @(posedge core_clk) disable iff (!rs_n)
      grant |=> !imr_q[`PSI_IMR_GE] && int_push)
      else $error("grant did not disable interrupts");
   a_isr_start: assert property (
      @(posedge core_clk) disable iff (!rs_n)
      grant |-> ##58 int_isr_start)
      else $error("service start not at clock 58");
   a_push_len: assert property (
      @(posedge core_clk) disable iff (!rs_n)
      grant |=> int_push ##47 int_push ##1 int_fetch ##8 int_fetch)
      else $error("push or fetch phase wrong length");
   a_tx_irq: assert property (
      @(posedge core_clk) disable iff (!rs_n)
      (tx_done && p3m_q[`PSI_M_SER]) |=> req_q[4])
      else $error("sent character raised no request four");
   a_rx_irq: assert property (
      @(posedge core_clk) disable iff (!rs_n)
      (rx_done_q && p3m_q[`PSI_M_SER]) |=> req_q[3] && rx_full_q)
      else $error("received character raised no request three");
   a_sw_set: assert property (
      @(posedge core_clk) disable iff (!rs_n)
      (bus.wr && bus.addr == `PSI_A_IRQ) |=>
      ((req_q & $past(bus.wdata[5:0])) == $past(bus.wdata[5:0])))
      else $error("software request not pending");
   a_tx_parity: assert property (
      @(posedge core_clk) disable iff (!rs_n)
      (wr_sio && !tx_busy && p3m_q[`PSI_M_SER] && p3m_q[`PSI_M_PAR]) |=>
      tx_sh_q[8] == psi_odd($past(bus.wdata[6:0])) && !tx_sh_q[0]
      && tx_sh_q[10:9] == 2'h3)
      else $error("transmit frame or parity wrong");
   a_tx_idle: assert property (
      @(posedge core_clk) disable iff (!rs_n)
      (p3m_q[`PSI_M_SER] && !tx_busy) |=> p3_out[7])
      else $error("serial line not idle high");
   a_od_nodrive: assert property (
      @(posedge core_clk) disable iff (!rs_n)
      (p3m_q[`PSI_M_OD] && p2_dat_q[0]) |=> !p2_oe[0])
      else $error("open-drain line driven high");

endmodule : psi_port

// >>> bench/psi_serial_partner.sv
module psi_serial_partner #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic core_clk,
   input  wire logic tx_line,
   output logic      rx_line
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] got_byte;
   int         got_stops;

   // receive line idles at the mark level
   initial rx_line = 1'b1;

   // capture device frames at mid-bit, lsb first, count stop bits
   initial begin
      got_byte = 8'h00;
      got_stops = 0;
      forever begin
         @(negedge tx_line);
         repeat (BIT_CLKS / 2) @(posedge core_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge core_clk);
            got_byte[i] = tx_line;
         end
         got_stops = 0;
         for (int i = 0; i < 2; i++) begin
            repeat (BIT_CLKS) @(posedge core_clk);
            if (tx_line === 1'b1) got_stops++;
         end
      end
   end

   // drive a plain level on the receive line
   task automatic mark(input logic v);
      @(posedge core_clk);
      rx_line <= v;
   endtask : mark

   // start bit, eight data bits lsb first, one stop bit only
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge core_clk);
         rx_line <= frame[i];
         repeat (BIT_CLKS - 1) @(posedge core_clk);
      end
   endtask : send_byte
endmodule : psi_serial_partner

// >>> bench/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // reload of zero gives one tick per clock, sixteen clocks per bit
   localparam int BITC = 16;
   localparam int LMAP [4] = '{3, 2, 0, 1};
   logic              core_clk, rst_n, instr_last, ser_rx;
   psi_pkg::psi_bus_t bus;
   logic [7:0]        rd_data, p2_in, p2_out, p2_oe, int_vector;
   logic [3:1]        p3_drv;
   logic [3:0]        p3_in;
   logic [7:4]        p3_out;
   logic              timer_out_src, data_memory_select, ready_port0;
   logic              timer_input, data_available_port0, int_ack;
   logic              int_push, int_fetch, int_isr_start;
   int                bad_count, checked;
   logic [7:0]        want;
   logic [1:0]        tmr_evt;

   assign p3_in = {p3_drv, ser_rx};

   psi_port uut (
      .core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
      .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe), .p3_in(p3_in),
      .p3_out(p3_out), .instr_last(instr_last), .timer_evt(tmr_evt),
      .timer_out_src(timer_out_src), .ready_port0(ready_port0),
      .data_memory_select(data_memory_select), .timer_input(timer_input),
      .data_available_port0(data_available_port0), .int_ack(int_ack),
      .int_push(int_push), .int_fetch(int_fetch),
      .int_isr_start(int_isr_start), .int_vector(int_vector)
   );

   psi_serial_partner #(.BIT_CLKS(BITC)) far (
      .core_clk(core_clk), .tx_line(p3_out[7]), .rx_line(ser_rx)
   );

   // 40 mhz clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] expv);
      checked++;
      if (seen !== expv) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, expv, seen);
      end
   endtask : chk

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run

   // one-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
   endtask : wr_reg

   // one-cycle read strobe, data taken in the following cycle
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      #1 v = rd_data;
   endtask : rd_reg

   task automatic rd_chk(input string w, input logic [7:0] a,
                         input logic [7:0] m, input logic [7:0] e);
      logic [7:0] v;
      rd_reg(a, v);
      chk(w, v & m, e);
   endtask : rd_chk

   // poll status bit with a bounded number of reads
   task automatic wait_stat(input int b, input logic val);
      logic [7:0] v;
      v = 8'h00;
      for (int n = 0; n < 400; n++) begin
         rd_reg(8'hfc, v);
         if (v[b] === val) break;
      end
      chk("status", {7'h0, v[b]}, {7'h0, val});
   endtask : wait_stat

   // one sample point, then measure the entry sequence
   task automatic grant_seq(input logic [7:0] vec);
      int np = 0;
      int nf = 0;
      int na = 0;
      int isr = 0;
      @(posedge core_clk);
      instr_last <= 1'b1;
      @(posedge core_clk);
      instr_last <= 1'b0;
      for (int i = 1; i <= 60; i++) begin
         if (i > 1) @(posedge core_clk);
         #1;
         if (i == 1) chk("vector", int_vector, vec);
         if (int_push === 1'b1) np++;
         if (int_fetch === 1'b1) nf++;
         if (int_ack === 1'b1) na++;
         if (int_isr_start === 1'b1) isr = i;
      end
      chk("push", 8'(np), 8'h30);
      chk("fetch", 8'(nf), 8'h09);
      chk("ack", 8'(na), 8'h39);
      chk("isr", 8'(isr), 8'h3a);
   endtask : grant_seq

   task automatic tx_one(input logic [7:0] d, input logic [7:0] e);
      wr_reg(8'hf0, d);
      wait_stat(0, 1'b0);
      chk("tx byte", far.got_byte, e);
      chk("tx stops", 8'(far.got_stops), 8'h02);
   endtask : tx_one

   task automatic rx_one(input logic [7:0] d, input logic [7:0] e);
      far.send_byte(d);
      wait_stat(1, 1'b1);
      rd_chk("rx byte", 8'hf0, 8'hff, e);
   endtask : rx_one

   // watchdog, well beyond the thousand or so cycles the tests take
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      $display("BAD watchdog expired");
      complete_run();
   end

   // main sequence
   initial begin
      bus = '0;
      p2_in = 8'h3c;
      p3_drv = 3'b111;
      instr_last = 1'b0;
      tmr_evt = 2'b00;
      timer_out_src = 1'b0;
      data_memory_select = 1'b1;
      ready_port0 = 1'b1;
      rst_n = 1'b0;
      bad_count = 0;
      checked = 0;
      repeat (4) @(posedge core_clk);
      #1 chk("rst p2 out", p2_out, 8'h00);
      chk("rst p2 oe", p2_oe, 8'h00);
      chk("rst p3 out", {4'h0, p3_out}, 8'h0f);
      chk("rst data_available_port0", {7'h0, data_available_port0}, 8'h01);
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd_chk("dir", 8'hf6, 8'hff, 8'hff);
      rd_chk("mask", 8'hfb, 8'hff, 8'h00);
      rd_chk("unmapped", 8'h10, 8'hff, 8'h00);
      // port two: low half input, high half output, then open drain
      wr_reg(8'hf6, 8'h0f);
      wr_reg(8'h02, 8'ha5);
      rd_chk("p2 read", 8'h02, 8'hff, 8'hac);
      chk("p2 out", p2_out, 8'ha5);
      chk("p2 oe", p2_oe, 8'hf0);
      wr_reg(8'hf7, 8'h01);
      rd_chk("p3 mode", 8'hf7, 8'hff, 8'h00);
      wr_reg(8'hf9, 8'h03);
      rd_chk("prio", 8'hf9, 8'hff, 8'h00);
      chk("p2 od", p2_oe, 8'h50);
      // falling input lines set requests while all are masked
      want = 8'h00;
      for (int i = 0; i < 4; i++) begin
         if (i == 0) far.mark(1'b0);
         else p3_drv[i] <= 1'b0;
         repeat (6) @(posedge core_clk);
         want[LMAP[i]] = 1'b1;
         rd_chk("line req", 8'hfa, 8'h2f, want);
         if (i == 0) far.mark(1'b1);
         else p3_drv[i] <= 1'b1;
      end
      wr_reg(8'hfa, 8'h20);
      rd_chk("sw req", 8'hfa, 8'h2f, 8'h2f);
      // start index two among enabled requests 0..3
      wr_reg(8'hf9, 8'h02);
      wr_reg(8'hfb, 8'h8f);
      grant_seq(8'h04);
      rd_chk("mask ge", 8'hfb, 8'hff, 8'h0f);
      rd_chk("req clr", 8'hfa, 8'h2f, 8'h2b);
      // alternate functions of port three
      wr_reg(8'hf7, 8'h1c);
      for (int k = 0; k < 2; k++) begin
         timer_out_src <= k[0];
         data_memory_select <= ~k[0];
         ready_port0 <= k[0];
         p3_drv[2:1] <= {~k[0], k[0]};
         repeat (6) @(posedge core_clk);
         #1 chk("p3 alt", {4'h0, p3_out}, {4'h0, 1'b0, k[0], k[0], ~k[0]});
         chk("tin", {7'h0, timer_input}, {7'h0, k[0]});
         chk("data_available_port0", {7'h0, data_available_port0}, {7'h0, ~k[0]});
      end
      p3_drv <= 3'b111;
      // serial mode, then clear the stale transmit request by a grant
      wr_reg(8'hf4, 8'h00);
      wr_reg(8'hf7, 8'h20);
      wr_reg(8'hf9, 8'h00);
      wr_reg(8'hfb, 8'h90);
      grant_seq(8'h08);
      rd_chk("tx req idle", 8'hfa, 8'h10, 8'h00);
      tx_one(8'h35, 8'h35);
      rd_chk("tx req", 8'hfa, 8'h10, 8'h10);
      wr_reg(8'hf7, 8'h60);
      tx_one(8'h35, 8'hb5);
      rx_one(8'h35, 8'hb5);
      rd_chk("rx req", 8'hfa, 8'h08, 8'h08);
      wr_reg(8'hf7, 8'h20);
      rx_one(8'hc6, 8'hc6);
      // grant request five, then a timer event sets it again
      wr_reg(8'hfb, 8'ha0);
      grant_seq(8'h0a);
      rd_chk("evt clr", 8'hfa, 8'h20, 8'h00);
      @(posedge core_clk);
      tmr_evt <= 2'b01;
      @(posedge core_clk);
      tmr_evt <= 2'b00;
      rd_chk("timer req", 8'hfa, 8'h20, 8'h20);
      complete_run();
   end
endmodule : tb_top
